// File: include/audio_rx_cfg_pkg.sv
package audio_rx_cfg_pkg;

	// register addresses sent before the data word
	localparam logic [7:0]  ADDR_SYSTEM  = 8'hE8;
	localparam logic [7:0]  ADDR_IO      = 8'hE9;
	localparam logic [7:0]  ADDR_EVENT   = 8'hEA;

	// serial word framing
	localparam int          ADDR_BITS    = 8;
	localparam int          WORD_BITS    = 16;
	localparam logic [4:0]  COUNT_FULL   = 5'h10;
	localparam logic [4:0]  COUNT_OVER   = 5'h11;

	// reset values and writable-bit masks
	localparam logic [15:0] SYSTEM_RESET = 16'h0000;
	localparam logic [15:0] IO_RESET     = 16'h0002;
	localparam logic [15:0] EVENT_RESET  = 16'h0000;
	localparam logic [15:0] SYSTEM_MASK  = 16'hFEFD;
	localparam logic [15:0] IO_MASK      = 16'h77FF;
	localparam logic [15:0] EVENT_MASK   = 16'hFF01;

	// system settings fields
	localparam int          SYS_RESET_BIT = 0;
	localparam int          LOW_POWER_LSB = 2;
	localparam int          PLL_STOP_BIT  = 4;
	localparam int          RATE_LSB      = 5;
	localparam int          HALVING_BIT   = 7;
	localparam int          OSC_RUN_BIT   = 9;
	localparam int          OSC_MODE_BIT  = 10;
	localparam int          SOURCE_BIT    = 11;
	localparam int          XTAL_LSB      = 12;
	localparam int          XTAL_LOOP_BIT = 15;

	// io data settings fields
	localparam int          SPARE_FN_BIT  = 0;
	localparam int          SPARE_LVL_BIT = 1;
	localparam int          LIMIT_BIT     = 2;
	localparam int          RANGE_BIT     = 3;
	localparam int          ALLOWED_LSB   = 4;
	localparam int          FORMAT_LSB    = 8;
	localparam int          UNLOCKED_BIT  = 12;
	localparam int          BYPASS_BIT    = 13;
	localparam int          MUTE_BIT      = 14;

	// event settings fields
	localparam int          HOLD_MODE_BIT = 0;
	localparam int          PIN_FN_BIT    = 8;
	localparam int          ENABLE_LSB    = 9;
	localparam int          EVENT_COUNT   = 7;

	// low power and locked rate codes
	localparam logic [1:0]  LP_OSC_ONLY   = 2'h1;
	localparam logic [1:0]  LP_OSC_DIV    = 2'h2;
	localparam logic [1:0]  RATE_512      = 2'h2;
	localparam logic [1:0]  RATE_512_HALF = 2'h3;

	// measured rate codes that name a target rate
	localparam logic [2:0]  MEAS_MIN      = 3'h1;
	localparam logic [2:0]  MEAS_MAX      = 3'h6;

	// accepted measured codes, bit n for code n+1; same in both ranges
	function automatic logic [5:0] rate_accept_mask(input logic [3:0] sel);
		case (sel)
			4'h1:    rate_accept_mask = 6'h01;
			4'h2:    rate_accept_mask = 6'h02;
			4'h3:    rate_accept_mask = 6'h04;
			4'h4:    rate_accept_mask = 6'h10;
			4'h5:    rate_accept_mask = 6'h20;
			4'h6:    rate_accept_mask = 6'h12;
			4'h7:    rate_accept_mask = 6'h24;
			4'h8:    rate_accept_mask = 6'h07;
			default: rate_accept_mask = 6'h3F;
		endcase
	endfunction

	// true when a rate change keeps the output clock running
	function automatic logic rate_seamless(input logic [1:0] a, input logic [1:0] b);
		rate_seamless = (a == b) ||
			((a == RATE_512 || a == RATE_512_HALF) && (b == RATE_512 || b == RATE_512_HALF));
	endfunction

endpackage

// File: rtl/serial_word_capture.sv
`timescale 1ns/100ps
`default_nettype none

module serial_word_capture (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        chipEnablePin,
	input  wire logic        serialShiftStrobe,
	input  wire logic        serialWriteLine,
	output logic             wordValid,
	output logic [7:0]       wordAddr,
	output logic [15:0]      wordData
);

	logic [2:0]  ceSync_reg;
	logic [2:0]  clSync_reg;
	logic [1:0]  diSync_reg;
	logic [7:0]  addrShift_reg;
	logic [15:0] dataShift_reg;
	logic [4:0]  bitCount_reg;
	logic        wordValid_reg;
	logic [7:0]  wordAddr_reg;
	logic [15:0] wordData_reg;
	logic        clRise;
	logic        ceRise;
	logic        ceFall;

	// two-flop synchronisers, third stage for edges
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ceSync_reg <= 3'h0;
			clSync_reg <= 3'h0;
			diSync_reg <= 2'h0;
		end else begin
			ceSync_reg <= {ceSync_reg[1:0], chipEnablePin};
			clSync_reg <= {clSync_reg[1:0], serialShiftStrobe};
			diSync_reg <= {diSync_reg[0], serialWriteLine};
		end
	end

	assign clRise = clSync_reg[1] & ~clSync_reg[2];
	assign ceRise = ceSync_reg[1] & ~ceSync_reg[2];
	assign ceFall = ~ceSync_reg[1] & ceSync_reg[2];

	// bits taken on strobe rise, first bit ends in bit 0
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			addrShift_reg <= 8'h00;
			dataShift_reg <= 16'h0000;
			bitCount_reg  <= 5'h00;
			wordAddr_reg  <= 8'h00;
		end else if (ceRise) begin
			wordAddr_reg <= addrShift_reg;
			bitCount_reg <= 5'h00;
		end else if (clRise) begin
			if (ceSync_reg[1]) begin
				dataShift_reg <= {diSync_reg[1], dataShift_reg[15:1]};
				if (bitCount_reg != audio_rx_cfg_pkg::COUNT_OVER) begin
					bitCount_reg <= bitCount_reg + 5'h01;
				end
			end else begin
				addrShift_reg <= {diSync_reg[1], addrShift_reg[7:1]};
			end
		end
	end

	// word handed on only after exactly sixteen bits and enable low
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wordValid_reg <= 1'b0;
			wordData_reg  <= 16'h0000;
		end else begin
			wordValid_reg <= ceFall && (bitCount_reg == audio_rx_cfg_pkg::COUNT_FULL);
			if (ceFall) begin
				wordData_reg <= dataShift_reg;
			end
		end
	end

	assign wordValid = wordValid_reg;
	assign wordAddr  = wordAddr_reg;
	assign wordData  = wordData_reg;

endmodule

`default_nettype wire

// File: rtl/audio_receiver_write_config.sv
// What this block does
// - set reset bit resets data, rate-error and event logic only
// - low power code selects running blocks
// - pll stop bit stops the pll
// - locked rate field picks master clock
// - switching codes 10/11 keeps clock running
// - halving bit halves master clock output
// - oscillator run and auto-stop mode bits
// - clock source bit forces crystal source
// - crystal field declares crystal frequency
// - spare pin level or clock-switch signal
// - limit bit feeds rate into error flag
// - range bit picks low or high rates
// - low range allowed-rate codes
// - high range allowed-rate codes
// - format field selects serial output format
// - unlocked bit mutes or passes input
// - bypass passes input, mute silences pin
// - event pin held until read or pulsed
// - event pin shows emphasis or interrupt
// - seven enables admit interrupt sources
// - rate update only without lock error
// - sixteen data bits on strobe rise
`timescale 1ns/100ps
`default_nettype none

module audio_receiver_write_config (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        chipEnablePin,
	input  wire logic        serialShiftStrobe,
	input  wire logic        serialWriteLine,
	input  wire logic        serialAudioInPin,
	input  wire logic        demodData,
	input  wire logic        pllLocked,
	input  wire logic        lockError,
	input  wire logic        nonPcm,
	input  wire logic        emphasis,
	input  wire logic        validity,
	input  wire logic [2:0]  rateCode,
	input  wire logic        chanStatUpdate,
	input  wire logic        subqLoad,
	input  wire logic        clockSwitchSignal,
	input  wire logic        statusRead,
	input  wire logic        fsTick,
	output logic             wholeChipReset,
	output logic             coreEnable,
	output logic             clockDividerEnable,
	output logic             oscAmpEnable,
	output logic             pllRun,
	output logic [1:0]       lockedClockRate,
	output logic             pllRelock,
	output logic             outputClockHalving,
	output logic             clockFromCrystal,
	output logic [3:0]       crystalFrequency,
	output logic             crystalLoopback,
	output logic             rateRangeHigh,
	output logic             rateErrorFlag,
	output logic             rateUpdateEvent,
	output logic [2:0]       outputFormat,
	output logic             serialAudioOutPin,
	output logic             spareOutputPin,
	output logic             eventPin
);

	logic        wordValid;
	logic [7:0]  wordAddr;
	logic [15:0] wordData;
	logic [15:0] sysCfg_reg;
	logic [15:0] ioCfg_reg;
	logic [15:0] evtCfg_reg;
	logic        pllRelock_reg;
	logic [1:0]  sdinSync_reg;
	logic [3:0]  prevLevels_reg;
	logic [2:0]  prevRate_reg;
	logic        primed_reg;
	logic        holdPend_reg;
	logic        pulsePend_reg;
	logic        eventPin_reg;
	logic        audioOut_reg;
	logic        spare_reg;
	logic        rateErr_reg;
	logic        chipReset;
	logic [1:0]  lowPower;
	logic [1:0]  newRate;
	logic [3:0]  curLevels;
	logic [3:0]  levelChange;
	logic        rateMoved;
	logic        rateUpdate;
	logic [6:0]  events;
	logic [6:0]  enables;
	logic        eventHit;
	logic        intSignal;
	logic [5:0]  acceptMask;
	logic        rateAccepted;
	logic        muteBit;
	logic        bypassBit;
	logic        unlockedBit;
	logic        holdMode;

	serial_word_capture capture (
		.ref_clk           (ref_clk),
		.sys_rst           (sys_rst),
		.chipEnablePin     (chipEnablePin),
		.serialShiftStrobe (serialShiftStrobe),
		.serialWriteLine   (serialWriteLine),
		.wordValid         (wordValid),
		.wordAddr          (wordAddr),
		.wordData          (wordData)
	);

	// register bank, unknown addresses ignored
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sysCfg_reg <= audio_rx_cfg_pkg::SYSTEM_RESET;
			ioCfg_reg  <= audio_rx_cfg_pkg::IO_RESET;
			evtCfg_reg <= audio_rx_cfg_pkg::EVENT_RESET;
		end else if (wordValid) begin
			case (wordAddr)
				audio_rx_cfg_pkg::ADDR_SYSTEM: begin
					sysCfg_reg <= wordData & audio_rx_cfg_pkg::SYSTEM_MASK;
				end
				audio_rx_cfg_pkg::ADDR_IO: begin
					ioCfg_reg <= wordData & audio_rx_cfg_pkg::IO_MASK;
				end
				audio_rx_cfg_pkg::ADDR_EVENT: begin
					evtCfg_reg <= wordData & audio_rx_cfg_pkg::EVENT_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	// reset bit resets data, rate-error and event logic; bank, capture, relock and spare pin untouched
	assign chipReset      = sys_rst | wholeChipReset;
	assign wholeChipReset = sysCfg_reg[audio_rx_cfg_pkg::SYS_RESET_BIT];

	// power and clock control
	assign lowPower = sysCfg_reg[audio_rx_cfg_pkg::LOW_POWER_LSB +: 2];
	assign coreEnable = (lowPower != audio_rx_cfg_pkg::LP_OSC_ONLY) &&
		(lowPower != audio_rx_cfg_pkg::LP_OSC_DIV);
	assign clockDividerEnable = coreEnable || (lowPower == audio_rx_cfg_pkg::LP_OSC_DIV);
	assign oscAmpEnable = ~sysCfg_reg[audio_rx_cfg_pkg::OSC_RUN_BIT] &
		(sysCfg_reg[audio_rx_cfg_pkg::OSC_MODE_BIT] | ~pllLocked | ~coreEnable);
	assign pllRun = ~sysCfg_reg[audio_rx_cfg_pkg::PLL_STOP_BIT] & coreEnable;
	assign lockedClockRate = sysCfg_reg[audio_rx_cfg_pkg::RATE_LSB +: 2];
	assign outputClockHalving = sysCfg_reg[audio_rx_cfg_pkg::HALVING_BIT];
	assign clockFromCrystal = sysCfg_reg[audio_rx_cfg_pkg::SOURCE_BIT] | ~pllLocked;
	assign crystalFrequency = sysCfg_reg[audio_rx_cfg_pkg::XTAL_LSB +: 4];
	assign crystalLoopback = sysCfg_reg[audio_rx_cfg_pkg::XTAL_LOOP_BIT];

	// relock request on a rate change that breaks clock continuity
	assign newRate = wordData[audio_rx_cfg_pkg::RATE_LSB +: 2];
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pllRelock_reg <= 1'b0;
		end else begin
			pllRelock_reg <= wordValid && (wordAddr == audio_rx_cfg_pkg::ADDR_SYSTEM) &&
				!audio_rx_cfg_pkg::rate_seamless(lockedClockRate, newRate);
		end
	end
	assign pllRelock = pllRelock_reg;

	// io settings
	assign rateRangeHigh = ioCfg_reg[audio_rx_cfg_pkg::RANGE_BIT];
	assign outputFormat  = ioCfg_reg[audio_rx_cfg_pkg::FORMAT_LSB +: 3];
	assign muteBit       = ioCfg_reg[audio_rx_cfg_pkg::MUTE_BIT];
	assign bypassBit     = ioCfg_reg[audio_rx_cfg_pkg::BYPASS_BIT];
	assign unlockedBit   = ioCfg_reg[audio_rx_cfg_pkg::UNLOCKED_BIT];

	// allowed rates, same code table in both ranges
	assign acceptMask = audio_rx_cfg_pkg::rate_accept_mask(
		ioCfg_reg[audio_rx_cfg_pkg::ALLOWED_LSB +: 4]);
	assign rateAccepted = (rateCode >= audio_rx_cfg_pkg::MEAS_MIN) &&
		(rateCode <= audio_rx_cfg_pkg::MEAS_MAX) &&
		acceptMask[rateCode - audio_rx_cfg_pkg::MEAS_MIN];

	always_ff @(posedge ref_clk) begin
		if (chipReset) begin
			rateErr_reg <= 1'b1;
		end else begin
			rateErr_reg <= lockError |
				(ioCfg_reg[audio_rx_cfg_pkg::LIMIT_BIT] & ~rateAccepted);
		end
	end
	assign rateErrorFlag = rateErr_reg;

	// serial audio input pin synchroniser
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sdinSync_reg <= 2'h0;
		end else begin
			sdinSync_reg <= {sdinSync_reg[0], serialAudioInPin};
		end
	end

	// data output selection, mute first
	always_ff @(posedge ref_clk) begin
		if (chipReset) begin
			audioOut_reg <= 1'b0;
		end else if (muteBit) begin
			audioOut_reg <= 1'b0;
		end else if (bypassBit) begin
			audioOut_reg <= sdinSync_reg[1];
		end else if (pllLocked) begin
			audioOut_reg <= demodData;
		end else begin
			audioOut_reg <= unlockedBit ? 1'b0 : sdinSync_reg[1];
		end
	end
	assign serialAudioOutPin = audioOut_reg;

	// spare pin
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			spare_reg <= 1'b1;
		end else if (ioCfg_reg[audio_rx_cfg_pkg::SPARE_FN_BIT]) begin
			spare_reg <= clockSwitchSignal;
		end else begin
			spare_reg <= ioCfg_reg[audio_rx_cfg_pkg::SPARE_LVL_BIT];
		end
	end
	assign spareOutputPin = spare_reg;

	// event sources
	assign curLevels = {validity, emphasis, nonPcm, lockError};
	always_ff @(posedge ref_clk) begin
		if (chipReset) begin
			prevLevels_reg <= 4'h0;
			prevRate_reg   <= 3'h0;
			primed_reg     <= 1'b0;
		end else begin
			prevLevels_reg <= curLevels;
			prevRate_reg   <= rateCode;
			primed_reg     <= 1'b1;
		end
	end

	assign levelChange = primed_reg ? (curLevels ^ prevLevels_reg) : 4'h0;
	assign rateMoved   = primed_reg && (rateCode != prevRate_reg);
	assign rateUpdate  = rateMoved & ~lockError & ~levelChange[0];
	assign rateUpdateEvent = rateUpdate;
	assign events  = {subqLoad, chanStatUpdate, rateUpdate, levelChange};
	assign enables = evtCfg_reg[audio_rx_cfg_pkg::ENABLE_LSB +: audio_rx_cfg_pkg::EVENT_COUNT];
	assign eventHit = |(events & enables);
	assign holdMode = evtCfg_reg[audio_rx_cfg_pkg::HOLD_MODE_BIT];

	// held until status read, new event wins over the read
	always_ff @(posedge ref_clk) begin
		if (chipReset) begin
			holdPend_reg <= 1'b0;
		end else begin
			holdPend_reg <= eventHit | (holdPend_reg & ~statusRead);
		end
	end

	// pulse ends on the next word tick
	always_ff @(posedge ref_clk) begin
		if (chipReset) begin
			pulsePend_reg <= 1'b0;
		end else begin
			pulsePend_reg <= eventHit | (pulsePend_reg & ~fsTick);
		end
	end

	assign intSignal = holdMode ? pulsePend_reg : holdPend_reg;

	always_ff @(posedge ref_clk) begin
		if (chipReset) begin
			eventPin_reg <= 1'b0;
		end else begin
			eventPin_reg <= evtCfg_reg[audio_rx_cfg_pkg::PIN_FN_BIT] ?
				intSignal : emphasis;
		end
	end
	assign eventPin = eventPin_reg;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_reset_bit;
		wholeChipReset |=> !eventPin && !serialAudioOutPin && rateErrorFlag;
	endproperty
	a_reset_bit: assert property (p_reset_bit) else $error("reset bit ignored");

	property p_short_word;
		!wordValid |=> $stable(sysCfg_reg) && $stable(ioCfg_reg) && $stable(evtCfg_reg);
	endproperty
	a_short_word: assert property (p_short_word) else $error("bank changed");

	property p_seamless;
		wordValid && wordAddr == audio_rx_cfg_pkg::ADDR_SYSTEM &&
			lockedClockRate == audio_rx_cfg_pkg::RATE_512 &&
			newRate == audio_rx_cfg_pkg::RATE_512_HALF |=> !pllRelock;
	endproperty
	a_seamless: assert property (p_seamless) else $error("relock on 10 to 11");

	property p_limit;
		!wholeChipReset && ioCfg_reg[audio_rx_cfg_pkg::LIMIT_BIT] && rateCode == 3'h0
			|=> rateErrorFlag;
	endproperty
	a_limit: assert property (p_limit) else $error("out of range rate accepted");

	property p_no_limit;
		!wholeChipReset && !ioCfg_reg[audio_rx_cfg_pkg::LIMIT_BIT] && !lockError
			|=> !rateErrorFlag;
	endproperty
	a_no_limit: assert property (p_no_limit) else $error("error without limit");

	property p_mute;
		muteBit |=> !serialAudioOutPin;
	endproperty
	a_mute: assert property (p_mute) else $error("mute ignored");

	property p_bypass;
		!chipReset && !muteBit && bypassBit |=> serialAudioOutPin == $past(sdinSync_reg[1]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass wrong");

	property p_unlocked;
		!muteBit && !bypassBit && !pllLocked && unlockedBit |=> !serialAudioOutPin;
	endproperty
	a_unlocked: assert property (p_unlocked) else $error("unlocked not muted");

	property p_hold;
		!chipReset && !holdMode && evtCfg_reg[audio_rx_cfg_pkg::PIN_FN_BIT] && eventHit
			##1 (!statusRead && !wholeChipReset)[*3] |=> eventPin;
	endproperty
	a_hold: assert property (p_hold) else $error("event pin dropped");

	property p_rate_lock;
		rateUpdateEvent |-> !lockError && $stable(lockError) && $changed(rateCode);
	endproperty
	a_rate_lock: assert property (p_rate_lock) else $error("update with lock error");

	property p_spare;
		!ioCfg_reg[audio_rx_cfg_pkg::SPARE_FN_BIT] ##1 $stable(ioCfg_reg)
			|-> spareOutputPin == ioCfg_reg[audio_rx_cfg_pkg::SPARE_LVL_BIT];
	endproperty
	a_spare: assert property (p_spare) else $error("spare level wrong");

	c_sys_write: cover property (wordValid && wordAddr == audio_rx_cfg_pkg::ADDR_SYSTEM);
	c_relock: cover property (pllRelock);
	c_event_pin: cover property (!eventPin ##1 eventPin);
	c_rate_update: cover property (rateUpdateEvent);

endmodule

`default_nettype wire

// File: test/serial_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module serial_host_model (
	input  wire logic ref_clk,
	output logic      chipEnablePin,
	output logic      serialShiftStrobe,
	output logic      serialWriteLine
);
	initial begin
		chipEnablePin = 1'b0;
		serialShiftStrobe = 1'b0;
		serialWriteLine = 1'b0;
	end

	// strobe high held four cycles, low at least five, data set up before the rise
	task automatic send_bit(input logic b);
		serialWriteLine = ~b;
		@(negedge ref_clk);
		serialWriteLine = b;
		repeat (4) @(negedge ref_clk);
		serialShiftStrobe = 1'b1;
		repeat (4) @(negedge ref_clk);
		serialShiftStrobe = 1'b0;
	endtask

	// callers pass words with reserved positions at zero
	task automatic write_word(input logic [7:0] addr, input logic [15:0] data, input int nbits);
		for (int i = 0; i < 8; i++) begin
			send_bit(addr[i]);
		end
		repeat (4) @(negedge ref_clk);
		chipEnablePin = 1'b1;
		for (int i = 0; i < nbits; i++) begin
			send_bit(data[i]);
		end
		repeat (4) @(negedge ref_clk);
		chipEnablePin = 1'b0;
		repeat (8) @(negedge ref_clk);
	endtask
endmodule

`default_nettype wire

// File: test/audio_receiver_write_config_test.sv
`timescale 1ns/100ps
`default_nettype none

module audio_receiver_write_config_test;
	logic       ref_clk = 1'b0, sys_rst = 1'b1;
	wire        chipEnablePin, serialShiftStrobe, serialWriteLine;
	logic       serialAudioInPin = 1'b0, demodData = 1'b0, pllLocked = 1'b0, lockError = 1'b0;
	logic       nonPcm = 1'b0, emphasis = 1'b0, validity = 1'b0, chanStatUpdate = 1'b0;
	logic       subqLoad = 1'b0, clockSwitchSignal = 1'b0, statusRead = 1'b0, fsTick = 1'b0;
	logic [2:0] rateCode = 3'h0;
	logic       wholeChipReset, coreEnable, clockDividerEnable, oscAmpEnable, pllRun, pllRelock;
	logic       outputClockHalving, clockFromCrystal, crystalLoopback, rateRangeHigh;
	logic       rateErrorFlag, rateUpdateEvent, serialAudioOutPin, spareOutputPin, eventPin;
	logic [1:0] lockedClockRate;
	logic [3:0] crystalFrequency;
	logic [2:0] outputFormat;
	int         failures = 0, nTests = 0, relocks = 0, rateEvents = 0;
	logic [5:0] accept [9] = '{6'h3F, 6'h01, 6'h02, 6'h04, 6'h10, 6'h20, 6'h12, 6'h24, 6'h07};
	logic [2:0] lpExp [4] = '{3'h7, 3'h1, 3'h3, 3'h7};

	serial_host_model u_host (.ref_clk, .chipEnablePin, .serialShiftStrobe, .serialWriteLine);

	audio_receiver_write_config u_dut (
		.ref_clk, .sys_rst, .chipEnablePin, .serialShiftStrobe, .serialWriteLine,
		.serialAudioInPin, .demodData, .pllLocked, .lockError, .nonPcm, .emphasis,
		.validity, .rateCode, .chanStatUpdate, .subqLoad, .clockSwitchSignal, .statusRead,
		.fsTick, .wholeChipReset, .coreEnable, .clockDividerEnable, .oscAmpEnable, .pllRun,
		.lockedClockRate, .pllRelock, .outputClockHalving, .clockFromCrystal,
		.crystalFrequency, .crystalLoopback, .rateRangeHigh, .rateErrorFlag,
		.rateUpdateEvent, .outputFormat, .serialAudioOutPin, .spareOutputPin, .eventPin
	);

	always #25 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		if (pllRelock === 1'b1) relocks++;
		if (rateUpdateEvent === 1'b1) rateEvents++;
	end

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		u_host.write_word(a, d, 16);
	endtask

	// one-cycle pulses: read, word tick, subcode load, channel status
	task automatic tick(input logic [3:0] w);
		{statusRead, fsTick, subqLoad, chanStatUpdate} = w;
		step(1);
		{statusRead, fsTick, subqLoad, chanStatUpdate} = 4'h0;
		step(2);
	endtask

	// sets lock, demod, serial_audio_in_pin; checks data pin against v[0]
	task automatic dout(input logic [15:0] io, input logic [3:0] v);
		{pllLocked, demodData, serialAudioInPin} = v[3:1];
		wr(8'hE9, io);
		chk(serialAudioOutPin, v[0]);
	endtask

	task automatic close_out;
		$display("%0d mismatches in %0d comparisons", failures, nTests);
		if (failures == 0 && nTests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		close_out();
	end

	initial begin
		step(2);
		sys_rst = 1'b0;
		step(1);
		chk({lockedClockRate, outputClockHalving}, 16'h0000);
		chk({crystalFrequency, outputFormat}, 16'h0000);
		chk({wholeChipReset, spareOutputPin, eventPin}, 16'h0002);
		chk({pllRun, coreEnable}, 16'h0003);
		$display("reset test done");
		relocks = 0;
		wr(8'hE8, 16'h90D0);
		chk({pllRun, lockedClockRate, outputClockHalving}, 16'h0005);
		chk({crystalFrequency, crystalLoopback}, 16'h0013);
		wr(8'hE8, 16'h00E0);
		chk({pllRun, lockedClockRate, 2'(relocks)}, 16'h001D);
		wr(8'hE8, 16'h0000);
		chk(16'(relocks), 16'h0002);
		for (int c = 0; c < 4; c++) begin
			wr(8'hE8, 16'(c << 2));
			chk({coreEnable, clockDividerEnable, oscAmpEnable}, 16'(lpExp[c]));
		end
		pllLocked = 1'b1;
		wr(8'hE8, 16'h0000);
		chk({oscAmpEnable, clockFromCrystal}, 16'h0000);
		wr(8'hE8, 16'h0C00);
		chk({oscAmpEnable, clockFromCrystal}, 16'h0003);
		wr(8'hE8, 16'h0600);
		chk(oscAmpEnable, 16'h0000);
		pllLocked = 1'b0;
		step(2);
		chk(clockFromCrystal, 16'h0001);
		wr(8'hE8, 16'h0021);
		chk({wholeChipReset, lockedClockRate}, 16'h0005);
		u_host.write_word(8'hE8, 16'h0080, 15);
		u_host.write_word(8'hEB, 16'h0080, 16);
		chk({wholeChipReset, outputClockHalving}, 16'h0002);
		wr(8'hE8, 16'h0080);
		chk({wholeChipReset, outputClockHalving}, 16'h0001);
		$display("system test done");
		for (int f = 0; f < 8; f++) begin
			wr(8'hE9, 16'((f << 8) | ((f & 1) << 3)));
			chk({rateRangeHigh, outputFormat}, 16'(((f & 1) << 3) | f));
		end
		for (int r = 0; r < 2; r++) begin
			for (int s = 0; s < 9; s++) begin
				wr(8'hE9, 16'(4 | (r << 3) | (s << 4)));
				for (int c = 1; c < 7; c++) begin
					rateCode = 3'(c);
					step(3);
					chk(rateErrorFlag, {15'h0, ~accept[s][c - 1]});
				end
			end
		end
		wr(8'hE9, 16'h0000);
		rateCode = 3'h0;
		step(3);
		chk(rateErrorFlag, 16'h0000);
		rateEvents = 0;
		rateCode = 3'h1;
		step(3);
		chk(16'(rateEvents), 16'h0001);
		lockError = 1'b1;
		step(2);
		rateCode = 3'h2;
		step(3);
		chk({rateErrorFlag, 15'(rateEvents)}, 16'h8001);
		lockError = 1'b0;
		step(2);
		$display("rate test done");
		dout(16'h0000, 4'hD);
		dout(16'h0000, 4'h3);
		dout(16'h1000, 4'h2);
		dout(16'h2000, 4'hB);
		dout(16'h6000, 4'hE);
		wr(8'hE9, 16'h0001);
		chk(spareOutputPin, 16'h0000);
		clockSwitchSignal = 1'b1;
		step(3);
		chk(spareOutputPin, 16'h0001);
		wr(8'hE9, 16'h0000);
		chk(spareOutputPin, 16'h0000);
		$display("output test done");
		emphasis = 1'b1;
		step(3);
		chk(eventPin, 16'h0001);
		emphasis = 1'b0;
		wr(8'hEA, 16'h8100);
		tick(4'h1);
		chk(eventPin, 16'h0000);
		tick(4'h2);
		step(4);
		chk(eventPin, 16'h0001);
		tick(4'h8);
		chk(eventPin, 16'h0000);
		wr(8'hEA, 16'h8101);
		tick(4'h2);
		chk(eventPin, 16'h0001);
		tick(4'h4);
		chk(eventPin, 16'h0000);
		tick(4'h8);
		for (int e = 0; e < 7; e++) begin
			wr(8'hEA, 16'h0100 | 16'(1 << (e + 9)));
			chk(eventPin, 16'h0000);
			{validity, emphasis, nonPcm, lockError} = 4'(1 << e);
			if (e == 4) rateCode = rateCode + 3'h1;
			tick({2'h0, e == 6, e == 5});
			chk(eventPin, 16'h0001);
			tick(4'h8);
			chk(eventPin, 16'h0000);
		end
		$display("event test done");
		close_out();
	end
endmodule

`default_nettype wire
